/* File: core/rx_demod_ctrl.v */
// Overview of operation
// - DC stage cutoff set by cut field
// - OOK uses low IF, offset LO
// - Complex filter bypassed when FSK selected
// - Strength in 0.5 dB, two-bit acquisition
// - Gain calibration runs during PLL start-up
// - OOK compares strength against selected threshold
// - Peak mode threshold is peak minus 6dB
// - Peak decays one step per period
// - Decay stops at floor threshold
// - Fixed floor or averaged strength threshold
// - Bit sync auto in packet, clock pin
// - Frequency error measured four bits, signed
// - Correction subtracted from carrier register
// - Correction starts on rx enable or request
// - Auto-clear drops previous correction first
// - Temperature trigger only standby or synth
// - Timeout if no flag after start
// - Timeout after flag plus strength timeout
// - Flag needs two consecutive samples above
`timescale 1ns/1ps
`include "rx_demod_defines.vh"
module rx_demod_ctrl #(
    parameter CLK_HZ = 40000000,
    parameter XTAL_HZ = 32000000
) (
    // Clock and reset
    input wire CLK,
    input wire RESETN,
    // Register port
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    // Front end samples
    input wire [7:0] AMPLITUDE,
    input wire signed [15:0] FREQ_DISC,
    input wire FSK_BIT,
    input wire [7:0] TEMP_ADC,
    input wire PLL_LOCKED,
    // Front end controls
    output reg LOW_IF_EN,
    output reg COMPLEX_BYPASS,
    output reg [2:0] DC_CUT_SEL,
    output reg GAIN_CAL,
    output reg TEMP_ADC_EN,
    output reg [23:0] CARRIER,
    // Host side
    output reg DATA_OUT,
    output reg RECOVERED_CLOCK_PIN,
    output reg STRENGTH_FLAG,
    output reg TIMEOUT_IRQ,
    output reg RECEIVER_READY_IRQ
);
    localparam ST_IDLE = 2'h0;
    localparam ST_CAL = 2'h1;
    localparam ST_WAIT = 2'h2;
    localparam ST_RUN = 2'h3;

    reg [7:0] mode_q, br_hi_q, br_lo_q, bw_q, peak_cfg_q, floor_q, corr_cfg_q;
    reg [7:0] sthr_q, rx_tmo_q, s_tmo_q, test_q, strength_q, temp_q;
    reg [15:0] fei_q, corr_q;
    reg [1:0] st_q;
    reg [15:0] bit_cnt_q;
    reg bit_tick_q;
    reg [7:0] peak_q, avg_q, dec_cnt_q;
    reg [9:0] samp_acc_q;
    reg [1:0] samp_n_q;
    reg above_q;
    reg [10:0] tmo_cnt_q;
    reg [2:0] fei_n_q;
    reg signed [19:0] fei_acc_q;
    reg fei_busy_q, fei_for_corr_q;
    reg clk_phase_q;

    wire [2:0] opmode = mode_q[`MODE_POS +: 3];
    wire [1:0] mod_sel = mode_q[`MOD_SEL_POS +: 2];
    wire is_rx = (opmode == `OPMODE_RX);
    wire [15:0] bit_period = {br_hi_q, br_lo_q};
    wire [1:0] kind = peak_cfg_q[`THRESH_KIND_POS +: 2];
    wire [2:0] decay_period = peak_cfg_q[`DECAY_PERIOD_POS +: 3];
    wire [2:0] decay_step = peak_cfg_q[`DECAY_STEP_POS +: 3];
    wire [7:0] peak_thr = (peak_q > `PEAK_DROP) ? peak_q - `PEAK_DROP : 8'h00;
    reg [7:0] thresh;

    // Bit period scaled from crystal units to this clock
    function [15:0] scale_period;
        input [15:0] p;
        reg [47:0] prod;
        reg [47:0] quot;
        begin
            prod = p * CLK_HZ;
            quot = prod / XTAL_HZ;
            // Longer bit periods than sixteen bits of clocks are not supported
            scale_period = quot[15:0];
        end
    endfunction

    function [7:0] sat_sub;
        input [7:0] a;
        input [7:0] b;
        begin
            sat_sub = (a > b) ? a - b : 8'h00;
        end
    endfunction

    wire [15:0] clk_per_bit = scale_period(bit_period);
    wire rx_enter = (st_q == ST_IDLE) && is_rx;
    wire [9:0] strength_sum = samp_acc_q + {2'h0, AMPLITUDE};
    // Sign extended before adding, so negative errors stay negative
    wire [15:0] fei_new = fei_acc_q[17:2] + {{2{FREQ_DISC[15]}}, FREQ_DISC[15:2]};
    wire wr_corr = WR && (ADDR == `OFS_CORRECTION);

    always @*
    begin
        case (kind)
            // peak less 6 dB, floor bound
            `KIND_PEAK: thresh = (peak_thr < floor_q) ? floor_q : peak_thr;
            `KIND_AVERAGE: thresh = avg_q;
            default: thresh = floor_q;
        endcase
    end

    // Register writes
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            mode_q <= `RST_MODE_CTRL;
            br_hi_q <= `RST_BIT_RATE_HIGH;
            br_lo_q <= `RST_BIT_RATE_LOW;
            bw_q <= `RST_CHANNEL_BW;
            peak_cfg_q <= `RST_OOK_PEAK;
            floor_q <= `RST_OOK_FLOOR;
            corr_cfg_q <= 8'h00;
            sthr_q <= `RST_STRENGTH_THRESH;
            rx_tmo_q <= 8'h00;
            s_tmo_q <= 8'h00;
            test_q <= 8'h00;
        end
        else if (WR)
        begin
            case (ADDR)
                `OFS_MODE_CTRL: mode_q <= WDATA;
                `OFS_BIT_RATE_HIGH: br_hi_q <= WDATA;
                `OFS_BIT_RATE_LOW: br_lo_q <= WDATA;
                `OFS_CHANNEL_BW: bw_q <= WDATA;
                `OFS_OOK_PEAK: peak_cfg_q <= WDATA;
                `OFS_OOK_FLOOR: floor_q <= WDATA;
                `OFS_CORRECTION: corr_cfg_q <= WDATA & 8'h0C;
                `OFS_STRENGTH_THRESH: sthr_q <= WDATA;
                `OFS_RX_START_TMO: rx_tmo_q <= WDATA;
                `OFS_STRENGTH_TMO: s_tmo_q <= WDATA;
                // test register stored for the host
                `OFS_TEST_PEAK: test_q <= WDATA;
                default: ;
            endcase
        end
        else if (mode_q[`TEMP_START_BIT] && !TEMP_ADC_EN)
            mode_q <= mode_q & 8'h7F;
    end

    // Bit clock and sequencer
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            bit_cnt_q <= 16'h0000;
            bit_tick_q <= 1'b0;
            st_q <= ST_IDLE;
            GAIN_CAL <= 1'b0;
        end
        else
        begin
            bit_tick_q <= 1'b0;
            if (!is_rx || bit_cnt_q + 16'h0001 >= clk_per_bit)
            begin
                bit_cnt_q <= 16'h0000;
                bit_tick_q <= is_rx;
            end
            else
                bit_cnt_q <= bit_cnt_q + 16'h0001;
            case (st_q)
                ST_IDLE:
                    if (is_rx)
                    begin
                        st_q <= ST_CAL;
                        GAIN_CAL <= 1'b1;
                    end
                ST_CAL:
                    if (!is_rx)
                    begin
                        st_q <= ST_IDLE;
                        GAIN_CAL <= 1'b0;
                    end
                    else if (PLL_LOCKED)
                    begin
                        st_q <= ST_WAIT;
                        GAIN_CAL <= 1'b0;
                    end
                ST_WAIT:
                    if (!is_rx)
                        st_q <= ST_IDLE;
                    else if (STRENGTH_FLAG)
                        st_q <= ST_RUN;
                ST_RUN:
                    if (!is_rx)
                        st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Strength, threshold flag, peak tracking
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            samp_acc_q <= 10'h000;
            samp_n_q <= 2'h0;
            strength_q <= 8'hFF;
            above_q <= 1'b0;
            STRENGTH_FLAG <= 1'b0;
            peak_q <= 8'h00;
            avg_q <= 8'h00;
            dec_cnt_q <= 8'h00;
            DATA_OUT <= 1'b0;
        end
        else if (!is_rx)
        begin
            samp_n_q <= 2'h0;
            samp_acc_q <= 10'h000;
            above_q <= 1'b0;
            STRENGTH_FLAG <= 1'b0;
        end
        else if (bit_tick_q)
        begin
            // one sample per two bit periods, 0.5 dB units
            if (samp_n_q == `STRENGTH_BITS - 1)
            begin
                samp_n_q <= 2'h0;
                samp_acc_q <= 10'h000;
                strength_q <= strength_sum[8:1];
                above_q <= (AMPLITUDE > sthr_q);
                if (above_q && AMPLITUDE > sthr_q && st_q == ST_WAIT)
                    STRENGTH_FLAG <= 1'b1;
            end
            else
            begin
                samp_n_q <= samp_n_q + 2'h1;
                samp_acc_q <= samp_acc_q + {2'h0, AMPLITUDE};
            end
            avg_q <= avg_q - (avg_q >> 3) + (AMPLITUDE >> 3);
            if (AMPLITUDE > peak_q)
            begin
                peak_q <= AMPLITUDE;
                dec_cnt_q <= 8'h00;
            end
            // decay one step each period while amplitude is not above the peak
            else if (dec_cnt_q >= {5'h00, decay_period})
            begin
                dec_cnt_q <= 8'h00;
                if (sat_sub(peak_q, {5'h00, decay_step}) > floor_q)
                    peak_q <= sat_sub(peak_q, {5'h00, decay_step});
                else if (peak_q > floor_q)
                    peak_q <= floor_q;
            end
            else
                dec_cnt_q <= dec_cnt_q + 8'h01;
            DATA_OUT <= (mod_sel == 2'h0) ? FSK_BIT : (AMPLITUDE > thresh);
        end
    end

    // bit sync clock pin, auto in packet mode
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            clk_phase_q <= 1'b0;
            RECOVERED_CLOCK_PIN <= 1'b0;
        end
        else
        begin
            if (bit_tick_q)
                clk_phase_q <= 1'b0;
            else if (bit_cnt_q == (clk_per_bit >> 1))
                clk_phase_q <= 1'b1;
            RECOVERED_CLOCK_PIN <= clk_phase_q && is_rx
                && (mode_q[`PACKET_MODE_BIT] || !mode_q[`SYNC_OFF_BIT]);
        end
    end

    // receive timeouts in units of 8 bits
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tmo_cnt_q <= 11'h000;
            TIMEOUT_IRQ <= 1'b0;
            RECEIVER_READY_IRQ <= 1'b0;
        end
        else
        begin
            TIMEOUT_IRQ <= 1'b0;
            RECEIVER_READY_IRQ <= (st_q == ST_CAL) && PLL_LOCKED && is_rx;
            if (st_q == ST_IDLE || (st_q == ST_WAIT && STRENGTH_FLAG))
                tmo_cnt_q <= 11'h000;
            else if (bit_tick_q)
            begin
                tmo_cnt_q <= tmo_cnt_q + 11'h001;
                if (st_q == ST_WAIT && rx_tmo_q != 8'h00
                    && tmo_cnt_q + 11'h001 == {rx_tmo_q, 3'h0})
                    TIMEOUT_IRQ <= 1'b1;
                if (st_q == ST_RUN && s_tmo_q != 8'h00
                    && tmo_cnt_q + 11'h001 == {s_tmo_q, 3'h0})
                    TIMEOUT_IRQ <= 1'b1;
            end
        end
    end

    // Frequency error estimate and correction
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            fei_q <= 16'h0000;
            corr_q <= 16'h0000;
            fei_acc_q <= 20'h00000;
            fei_n_q <= 3'h0;
            fei_busy_q <= 1'b0;
            fei_for_corr_q <= 1'b0;
            CARRIER <= `RST_CARRIER;
        end
        else
        begin
            if (WR && ADDR == `OFS_CARRIER_HIGH)
                CARRIER[23:16] <= WDATA;
            if (WR && ADDR == `OFS_CARRIER_MID)
                CARRIER[15:8] <= WDATA;
            if (WR && ADDR == `OFS_CARRIER_LOW)
                CARRIER[7:0] <= WDATA;
            if (wr_corr && WDATA[`CORR_CLEAR_BIT])
            begin
                CARRIER <= CARRIER + {{8{corr_q[15]}}, corr_q};
                corr_q <= 16'h0000;
            end
            // start on rx entry when auto, else on request
            if (!fei_busy_q && ((rx_enter && corr_cfg_q[`CORR_AUTO_EN_BIT])
                || (wr_corr && WDATA[`CORR_START_BIT] && !WDATA[`CORR_AUTO_EN_BIT])
                || (wr_corr && WDATA[`FEI_START_BIT])))
            begin
                fei_busy_q <= 1'b1;
                fei_n_q <= 3'h0;
                fei_acc_q <= 20'h00000;
                fei_for_corr_q <= !(wr_corr && WDATA[`FEI_START_BIT]);
                if (rx_enter && corr_cfg_q[`CORR_AUTO_CLEAR_BIT])
                begin
                    CARRIER <= CARRIER + {{8{corr_q[15]}}, corr_q};
                    corr_q <= 16'h0000;
                end
            end
            else if (fei_busy_q && bit_tick_q)
            begin
                // four bit periods, two's complement result
                if (fei_n_q == `FEI_BITS - 1)
                begin
                    fei_busy_q <= 1'b0;
                    fei_q <= fei_new;
                    if (fei_for_corr_q)
                    begin
                        corr_q <= corr_q + fei_new;
                        CARRIER <= CARRIER - {{8{fei_new[15]}}, fei_new};
                    end
                end
                else
                begin
                    fei_n_q <= fei_n_q + 3'h1;
                    fei_acc_q <= fei_acc_q + {{4{FREQ_DISC[15]}}, FREQ_DISC};
                end
            end
        end
    end

    // temperature only in standby or synth
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            TEMP_ADC_EN <= 1'b0;
            temp_q <= 8'h00;
        end
        else if (TEMP_ADC_EN)
        begin
            TEMP_ADC_EN <= 1'b0;
            temp_q <= TEMP_ADC;
        end
        else if (mode_q[`TEMP_START_BIT]
            && (opmode == `OPMODE_STANDBY || opmode == `OPMODE_SYNTH))
            TEMP_ADC_EN <= 1'b1;
    end

    // Front end steering, reads
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            LOW_IF_EN <= 1'b0;
            COMPLEX_BYPASS <= 1'b1;
            DC_CUT_SEL <= 3'h2;
            RDATA <= 8'h00;
        end
        else
        begin
            LOW_IF_EN <= (mod_sel == 2'h1);
            COMPLEX_BYPASS <= (mod_sel == 2'h0);
            DC_CUT_SEL <= bw_q[`DC_CUT_POS +: 3];
            if (RD)
            begin
                case (ADDR)
                    `OFS_MODE_CTRL: RDATA <= mode_q;
                    `OFS_BIT_RATE_HIGH: RDATA <= br_hi_q;
                    `OFS_BIT_RATE_LOW: RDATA <= br_lo_q;
                    `OFS_CHANNEL_BW: RDATA <= bw_q;
                    `OFS_OOK_PEAK: RDATA <= peak_cfg_q;
                    `OFS_OOK_FLOOR: RDATA <= floor_q;
                    `OFS_CORRECTION: RDATA <= corr_cfg_q | {3'h0, fei_busy_q, 4'h0};
                    `OFS_STRENGTH_THRESH: RDATA <= sthr_q;
                    `OFS_RX_START_TMO: RDATA <= rx_tmo_q;
                    `OFS_STRENGTH_TMO: RDATA <= s_tmo_q;
                    `OFS_STRENGTH_VALUE: RDATA <= strength_q;
                    `OFS_FREQ_ERR_HIGH: RDATA <= fei_q[15:8];
                    `OFS_FREQ_ERR_LOW: RDATA <= fei_q[7:0];
                    `OFS_FREQ_CORR_HIGH: RDATA <= corr_q[15:8];
                    `OFS_FREQ_CORR_LOW: RDATA <= corr_q[7:0];
                    `OFS_CARRIER_HIGH: RDATA <= CARRIER[23:16];
                    `OFS_CARRIER_MID: RDATA <= CARRIER[15:8];
                    `OFS_CARRIER_LOW: RDATA <= CARRIER[7:0];
                    `OFS_STATUS: RDATA <= {4'h0, st_q, STRENGTH_FLAG, fei_busy_q};
                    `OFS_TEMP_VALUE: RDATA <= temp_q;
                    `OFS_TEST_PEAK: RDATA <= test_q;
                    default: RDATA <= 8'h00;
                endcase
            end
            else
                RDATA <= 8'h00;
        end
    end
endmodule // rx_demod_ctrl

/* File: pkg/rx_demod_defines.vh */
`ifndef RX_DEMOD_DEFINES_VH
`define RX_DEMOD_DEFINES_VH
// Register offsets
`define OFS_MODE_CTRL 8'h00
`define OFS_BIT_RATE_HIGH 8'h01
`define OFS_BIT_RATE_LOW 8'h02
`define OFS_CHANNEL_BW 8'h03
`define OFS_OOK_PEAK 8'h04
`define OFS_OOK_FLOOR 8'h05
`define OFS_CORRECTION 8'h06
`define OFS_STRENGTH_THRESH 8'h07
`define OFS_RX_START_TMO 8'h08
`define OFS_STRENGTH_TMO 8'h09
`define OFS_STRENGTH_VALUE 8'h0A
`define OFS_FREQ_ERR_HIGH 8'h0B
`define OFS_FREQ_ERR_LOW 8'h0C
`define OFS_FREQ_CORR_HIGH 8'h0D
`define OFS_FREQ_CORR_LOW 8'h0E
`define OFS_CARRIER_HIGH 8'h0F
`define OFS_CARRIER_MID 8'h10
`define OFS_CARRIER_LOW 8'h11
`define OFS_STATUS 8'h12
`define OFS_TEMP_VALUE 8'h13
`define OFS_TEST_PEAK 8'h6E
// Mode control fields
`define MODE_POS 0
`define MOD_SEL_POS 3
`define PACKET_MODE_BIT 5
`define SYNC_OFF_BIT 6
`define TEMP_START_BIT 7
// Operating modes
`define OPMODE_STANDBY 3'h1
`define OPMODE_SYNTH 3'h2
`define OPMODE_RX 3'h4
// OOK peak config fields
`define DECAY_PERIOD_POS 0
`define DECAY_STEP_POS 3
`define THRESH_KIND_POS 6
`define KIND_FIXED 2'h0
`define KIND_PEAK 2'h1
`define KIND_AVERAGE 2'h2
// Channel bw config fields
`define DC_CUT_POS 5
// Correction config bits
`define CORR_START_BIT 0
`define CORR_CLEAR_BIT 1
`define CORR_AUTO_EN_BIT 2
`define CORR_AUTO_CLEAR_BIT 3
`define FEI_START_BIT 4
// Reset values
`define RST_MODE_CTRL 8'h01
`define RST_BIT_RATE_HIGH 8'h1A
`define RST_BIT_RATE_LOW 8'h0B
`define RST_CHANNEL_BW 8'h55
`define RST_OOK_PEAK 8'h40
`define RST_OOK_FLOOR 8'h06
`define RST_STRENGTH_THRESH 8'hE4
`define RST_CARRIER 24'hE4C000
// Timing in bit periods
`define STRENGTH_BITS 2
`define FEI_BITS 4
`define TIMEOUT_UNIT_BITS 8
// Peak threshold offset: 6 dB at 0.5 dB per count
`define PEAK_DROP 8'h0C
`endif

/* File: tb/rx_demod_ctrl_monitor.sv */
`timescale 1ns/1ps
module rx_demod_ctrl_monitor (
    // Clock, reset and register port
    input wire CLK,
    input wire RESETN,
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [7:0] RDATA,
    // Front end and host side
    input wire [7:0] AMPLITUDE,
    input wire PLL_LOCKED,
    input wire LOW_IF_EN,
    input wire COMPLEX_BYPASS,
    input wire [2:0] DC_CUT_SEL,
    input wire GAIN_CAL,
    input wire TEMP_ADC_EN,
    input wire STRENGTH_FLAG,
    input wire TIMEOUT_IRQ
);
    reg [2:0] mode_q;
    reg [7:0] thr_q;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    // Shadows of the mode and strength threshold writes
    always @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            mode_q <= 3'h1;
            thr_q <= 8'hE4;
        end
        else if (WR && ADDR == 8'h00)
            mode_q <= WDATA[2:0];
        else if (WR && ADDR == 8'h07)
            thr_q <= WDATA;
    end
    a_read_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside read slot");
    a_fsk_bypass: assert property (WR && ADDR == 8'h00 |-> ##2
        COMPLEX_BYPASS == ($past(WDATA[4:3], 2) == 2'h0))
        else $error("bypass does not follow fsk select");
    a_ook_low_if: assert property (WR && ADDR == 8'h00 |-> ##2
        LOW_IF_EN == ($past(WDATA[4:3], 2) == 2'h1))
        else $error("low if does not follow ook select");
    a_dc_cut_follow: assert property (WR && ADDR == 8'h03 |-> ##2
        DC_CUT_SEL == $past(WDATA[7:5], 2))
        else $error("dc cut select does not follow field");
    a_timeout_pulse: assert property (TIMEOUT_IRQ |=> !TIMEOUT_IRQ)
        else $error("timeout interrupt longer than one cycle");
    a_temp_mode_gate: assert property (TEMP_ADC_EN |->
        (mode_q == 3'h1 || mode_q == 3'h2) ##1 !TEMP_ADC_EN)
        else $error("temperature conversion outside standby or synth");
    a_cal_ends_lock: assert property (GAIN_CAL && PLL_LOCKED |-> ##[0:2] !GAIN_CAL)
        else $error("gain calibration kept after lock");
    a_flag_above_thr: assert property ($rose(STRENGTH_FLAG) |-> $past(AMPLITUDE) > thr_q)
        else $error("strength flag raised below threshold");
endmodule // rx_demod_ctrl_monitor

bind rx_demod_ctrl rx_demod_ctrl_monitor mon_u (
    .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .AMPLITUDE(AMPLITUDE), .PLL_LOCKED(PLL_LOCKED),
    .LOW_IF_EN(LOW_IF_EN), .COMPLEX_BYPASS(COMPLEX_BYPASS), .DC_CUT_SEL(DC_CUT_SEL),
    .GAIN_CAL(GAIN_CAL), .TEMP_ADC_EN(TEMP_ADC_EN), .STRENGTH_FLAG(STRENGTH_FLAG),
    .TIMEOUT_IRQ(TIMEOUT_IRQ)
);

/* File: tb/rf_front_model.sv */
`timescale 1ns/1ps
module rf_front_model #(
    parameter BIT_CLKS = 20,
    parameter LOCK_CLKS = 10
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Scenario controls
    input wire synth_on,
    input wire temp_adc_en,
    input wire [7:0] amp_set,
    input wire signed [15:0] disc_set,
    input wire [7:0] temp_set,
    // Samples toward the receiver core
    output reg [7:0] amplitude,
    output wire signed [15:0] freq_disc,
    output reg fsk_bit,
    output wire [7:0] temp_adc,
    output reg pll_locked
);
    integer lock_cnt;
    integer bit_cnt;
    reg [3:0] conv_q;
    reg [7:0] stale_q;
    assign freq_disc = disc_set;
    // code valid only around a conversion, garbage otherwise
    assign temp_adc = (temp_adc_en || |conv_q) ? temp_set : stale_q;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lock_cnt <= 0;
            bit_cnt <= 0;
            amplitude <= 8'h00;
            fsk_bit <= 1'b0;
            conv_q <= 4'h0;
            stale_q <= 8'h00;
            pll_locked <= 1'b0;
        end
        else
        begin
            amplitude <= amp_set;
            conv_q <= {conv_q[2:0], temp_adc_en};
            stale_q <= ~stale_q;
            // Lock only after the synthesizer has settled
            lock_cnt <= synth_on ? lock_cnt + 1 : 0;
            pll_locked <= synth_on && lock_cnt >= LOCK_CLKS;
            bit_cnt <= (bit_cnt == BIT_CLKS - 1) ? 0 : bit_cnt + 1;
            if (bit_cnt == BIT_CLKS - 1)
                fsk_bit <= ~fsk_bit;
        end
    end
endmodule // rf_front_model

/* File: tb/rx_demod_ctrl_tb.sv */
`timescale 1ns/1ps
module rx_demod_ctrl_tb;
    // Bit rate 0x0010 crystal cycles gives 20 core cycles per bit
    localparam BIT = 20;
    localparam LOCK = 10;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg synth_on = 1'b0;
    reg [7:0] amp_set = 8'h00;
    reg signed [15:0] disc_set = 16'sh0000;
    reg [7:0] temp_set = 8'h3C;
    wire [7:0] rdata, amplitude, temp_adc;
    wire signed [15:0] freq_disc;
    wire fsk_bit, pll_locked, low_if, bypass, gain_cal, temp_en;
    wire [2:0] dc_cut;
    wire [23:0] carrier;
    wire data_out, flag, tmo_irq, rclk, rdy;
    reg rclk_q = 1'b0;
    integer rclk_n = 0;
    integer rdy_n = 0;
    integer err_total = 0;
    integer total_checks = 0;
    integer i, n;
    reg [7:0] v, hi;
    reg [23:0] exp_car;
    reg [15:0] tab [0:10] = '{16'h0001, 16'h011A, 16'h020B, 16'h0355, 16'h0440,
        16'h0506, 16'h07E4, 16'h0FE4, 16'h10C0, 16'h1100, 16'h2000};
    reg [11:0] ook [0:4] = '{12'h301, 12'h2ED, 12'h460, 12'h020, 12'h061};
    always #12.5 clk = ~clk;
    // Rising edges of the bit clock pin and ready pulses
    always @(posedge clk)
    begin
        rclk_q <= rclk;
        if (rclk && !rclk_q)
            rclk_n <= rclk_n + 1;
        if (rdy)
            rdy_n <= rdy_n + 1;
    end
    rf_front_model #(.BIT_CLKS(BIT), .LOCK_CLKS(LOCK)) fe_u (.clk(clk), .resetn(resetn),
        .synth_on(synth_on), .temp_adc_en(temp_en), .amp_set(amp_set),
        .disc_set(disc_set), .temp_set(temp_set), .amplitude(amplitude),
        .freq_disc(freq_disc), .fsk_bit(fsk_bit), .temp_adc(temp_adc),
        .pll_locked(pll_locked));
    rx_demod_ctrl dut_u (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .AMPLITUDE(amplitude), .FREQ_DISC(freq_disc),
        .FSK_BIT(fsk_bit), .TEMP_ADC(temp_adc), .PLL_LOCKED(pll_locked),
        .LOW_IF_EN(low_if), .COMPLEX_BYPASS(bypass), .DC_CUT_SEL(dc_cut),
        .GAIN_CAL(gain_cal), .TEMP_ADC_EN(temp_en), .CARRIER(carrier),
        .DATA_OUT(data_out), .RECOVERED_CLOCK_PIN(rclk), .STRENGTH_FLAG(flag),
        .TIMEOUT_IRQ(tmo_irq), .RECEIVER_READY_IRQ(rdy));
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task check(input string what, input [23:0] seen, input [23:0] expv);
    begin
        total_checks = total_checks + 1;
        if (seen !== expv)
        begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", what, expv, seen);
        end
    end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
    begin
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    end
    endtask
    task rd_reg(input [7:0] a, output [7:0] d);
    begin
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge clk);
    end
    endtask
    task set_mode(input [7:0] m);
    begin
        wr_reg(8'h00, m);
        synth_on <= (m[2:0] == 3'h4 || m[2:0] == 3'h2);
    end
    endtask
    // Polls the timeout pulse (sel 0) or the strength flag (sel 1)
    task wait_for(input integer sel, input integer lim);
    begin
        n = 0;
        while ((sel == 0 ? tmo_irq : flag) !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        if (n >= lim)
        begin
            err_total = err_total + 1;
            $display("[FAIL] wait %0d expected event seen none", sel);
            print_verdict;
        end
    end
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        check("bypass", bypass, 1'b1);
        check("dc cut", dc_cut, 3'h2);
        check("carrier", carrier, 24'hE4C000);
        wr_reg(8'h20, 8'hFF);
        for (i = 0; i < 11; i = i + 1)
        begin
            rd_reg(tab[i][15:8], v);
            check("reset value", v, tab[i][7:0]);
        end
        for (i = 0; i < 2; i = i + 1)
        begin
            set_mode({3'h0, i[1:0], 3'h1});
            @(posedge clk);
            #1;
            check("bypass", bypass, i == 0);
            check("low if", low_if, i == 1);
        end
        wr_reg(8'h03, 8'hE5);
        @(posedge clk);
        #1;
        check("dc cut", dc_cut, 3'h7);
        wr_reg(8'h00, 8'h81);
        repeat (3) @(posedge clk);
        rd_reg(8'h13, v);
        check("temp", v, 8'h3C);
        temp_set <= 8'h11;
        wr_reg(8'h00, 8'h80);
        repeat (3) @(posedge clk);
        rd_reg(8'h13, v);
        check("temp gated", v, 8'h3C);
        set_mode(8'h01);
        $display("test registers done");
        wr_reg(8'h01, 8'h00);
        wr_reg(8'h02, 8'h10);
        wr_reg(8'h07, 8'hFF);
        wr_reg(8'h08, 8'h01);
        set_mode(8'h04);
        repeat (2) @(posedge clk);
        #1;
        check("gain cal", gain_cal, 1'b1);
        wait_for(0, 1000);
        check("rx tmo", n >= 8 * BIT - 8 && n <= 9 * BIT + LOCK + 8, 1'b1);
        check("clock pin", rclk_n, 8);
        check("ready irq", rdy_n, 1);
        set_mode(8'h01);
        wr_reg(8'h07, 8'h40);
        wr_reg(8'h08, 8'h00);
        wr_reg(8'h09, 8'h01);
        amp_set <= 8'h80;
        set_mode(8'h04);
        wait_for(1, 600);
        wait_for(0, 1000);
        check("flag tmo", n >= 8 * BIT - 8 && n <= 9 * BIT + 8, 1'b1);
        rd_reg(8'h0A, v);
        check("strength", v, 8'h80);
        $display("test timeouts done");
        disc_set <= -16'sh0028;
        wr_reg(8'h06, 8'h10);
        i = 0;
        v = 8'h10;
        while (v[4] !== 1'b0 && i < 200)
        begin
            rd_reg(8'h06, v);
            i = i + 1;
        end
        check("fei time", 2 * i >= 4 * BIT - 4 && i < 200, 1'b1);
        rd_reg(8'h0B, v);
        check("fei sign", v[7], 1'b1);
        wr_reg(8'h06, 8'h01);
        repeat (6 * BIT) @(posedge clk);
        rd_reg(8'h0D, hi);
        rd_reg(8'h0E, v);
        check("corr value", {hi, v}, 16'hFFD8);
        exp_car = 24'hE4C000 - {{8{hi[7]}}, hi, v};
        check("carrier", carrier, exp_car);
        rd_reg(8'h0F, v);
        check("carrier high", v, exp_car[23:16]);
        $display("test correction done");
        set_mode(8'h09);
        wr_reg(8'h6E, 8'h0C);
        wr_reg(8'h05, 8'h20);
        set_mode(8'h0C);
        for (i = 0; i < 5; i = i + 1)
        begin
            wr_reg(8'h04, {ook[i][10:9], 6'h00});
            amp_set <= ook[i][8:1];
            repeat (4 * BIT) @(posedge clk);
            #1;
            check("ook data", data_out, ook[i][0]);
        end
        $display("test ook done");
        print_verdict;
    end
endmodule // rx_demod_ctrl_tb
